// ==== inc/pha_consts.svh ====
`ifndef PHA_CONSTS_SVH
`define PHA_CONSTS_SVH

// clocks an idle bus may stay granted to an external master before the grant is taken back
`define PHA_GNT_TIMEOUT_CLKS 5'h10
// data phase clocks allowed without target ready before giving up
`define PHA_SC_ABORT_CLKS    3'h5
// command lane value of the special cycle address phase
`define PHA_CBE_SPECIAL      4'h1
// byte enables of the halt message data phase (lanes 1 and 0 on)
`define PHA_CBE_HALT_DATA    4'hC
// halt message code on the low data lines
`define PHA_MSG_HALT         16'h0001
// rotation select codes
`define PHA_ROT_FIXED        3'h0
`define PHA_ROT_FULL         3'h7
// agent index of the processor; 0..2 are the external masters
`define PHA_CPU_ID           2'h3
// reset values
`define PHA_GNT_RST          4'h0
`define PHA_OWNER_RST        2'h3

`endif

// ==== inc/pha_pkg.sv ====
package pha_pkg;

    // arbitration settings, static while the bus runs
    typedef struct packed {
        logic       alternate_processor_priority;
        logic [2:0] fixed_priority_order;
        logic [2:0] rotation_scheme_select;
    } pha_cfg_t;

    // everything the block drives onto the shared bus lines
    typedef struct packed {
        logic        frame_b;
        logic        frame_oe;
        logic        irdy_b;
        logic        irdy_oe;
        logic [3:0]  cbe_b;
        logic [31:0] ad;
        logic        dat_oe;
    } pha_drv_t;

    // grant sequencer states
    typedef enum logic [1:0] {
        PHA_ST_IDLE  = 2'b00,
        PHA_ST_FLUSH = 2'b01,
        PHA_ST_GRANT = 2'b10
    } pha_arb_st_t;

    // halt special cycle states
    typedef enum logic [1:0] {
        PHA_SC_IDLE = 2'b00,
        PHA_SC_ADDR = 2'b01,
        PHA_SC_DATA = 2'b10,
        PHA_SC_TURN = 2'b11
    } pha_sc_st_t;

endpackage

// ==== src/pha_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser; first stage feeds only the second
module pha_sync #(
    parameter int W = 1
) (
    // destination clock
    input  wire logic         clk,
    // asynchronous data in, synchronised data out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;   // metastability catcher

    // no reset: the chain flushes itself in two edges
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end

endmodule

`default_nettype wire

// ==== src/pha_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pha_consts.svh"

module pha_arbiter (
    // system side
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire pha_pkg::pha_cfg_t cfg_in,
    input  wire logic              cpu_req,
    input  wire logic              halt_exec,
    input  wire logic              buf_empty,
    output logic                   buf_flush,
    output logic                   cpu_grant,
    // bus side
    input  wire logic              clk_pci,
    input  wire logic [2:0]        req_b,
    input  wire logic              frame_b_i,
    input  wire logic              irdy_b_i,
    input  wire logic              trdy_b_i,
    output logic [2:0]             gnt_b,
    output pha_pkg::pha_drv_t      pci_drv
);

    // winner search: returns {found, agent}
    function automatic logic [2:0] pick(
        input logic [3:0]        rq,
        input pha_pkg::pha_cfg_t c,
        input logic [1:0]        last
    );
        logic [5:0] ex;    // external order {lowest, mid, highest}
        logic [7:0] ord;   // full order, low slot is highest
        logic [3:0] m;     // requests after the alternating filter
        logic [2:0] res;
        ex  = 6'h24;
        ord = 8'hE4;
        m   = rq;
        res = 3'h0;
        // external order table; reserved codes fall back to 0,1,2
        case (c.fixed_priority_order)
            3'h1:    ex = 6'h21;
            3'h2:    ex = 6'h18;
            3'h4:    ex = 6'h09;
            3'h6:    ex = 6'h06;
            3'h7:    ex = 6'h12;
            default: ex = 6'h24;
        endcase
        if (c.rotation_scheme_select == `PHA_ROT_FIXED) begin
            ord = {`PHA_CPU_ID, ex};
        end else if (c.rotation_scheme_select == `PHA_ROT_FULL) begin
            for (int i = 0; i < 4; i++) begin
                ord[2*i +: 2] = last + 2'(i + 1);
            end
        end else if (last == ex[1:0]) begin
            // hybrid: externals rotate, processor stays last
            ord = {`PHA_CPU_ID, ex[1:0], ex[5:2]};
        end else if (last == ex[3:2]) begin
            ord = {`PHA_CPU_ID, ex[3:2], ex[1:0], ex[5:4]};
        end else begin
            ord = {`PHA_CPU_ID, ex};
        end
        // alternating: processor after every external turn
        if (c.alternate_processor_priority) begin
            if (last != `PHA_CPU_ID && rq[3]) begin
                m = 4'h8;
            end else if (last == `PHA_CPU_ID && |rq[2:0]) begin
                m[3] = 1'b0;
            end
        end
        // scan lowest priority first so the highest lands last
        for (int i = 3; i >= 0; i--) begin
            if (m[ord[2*i +: 2]]) begin
                res = {1'b1, ord[2*i +: 2]};
            end
        end
        return res;
    endfunction

    // ---------------- system domain ----------------
    logic [1:0] sys_s;         // {flush request, processor grant}
    logic       halt_tgl_r;    // flips once per halt event
    logic       flush_ack_r;   // flush done, held until request drops

    // halt event to a toggle so no pulse is lost crossing over
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            halt_tgl_r <= 1'b0;
        end else if (halt_exec) begin
            halt_tgl_r <= ~halt_tgl_r;
        end
    end

    // four-phase flush handshake, acked once buffers drain
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            flush_ack_r <= 1'b0;
        end else begin
            flush_ack_r <= sys_s[1] & (flush_ack_r | buf_empty);
        end
    end

    assign buf_flush = sys_s[1] & ~flush_ack_r;
    assign cpu_grant = sys_s[0];

    // ---------------- bus domain crossings ----------------
    logic                  rst_pci_b;   // reset seen on bus clock
    logic [5:0]            pin_s;       // {trdy, irdy, frame, req[2:0]}
    logic [9:0]            x_s;         // {cfg, cpu_req, halt, ack}
    pha_pkg::pha_cfg_t     cfg_s;
    logic [3:0]            gnt_r;       // one-hot, bit 3 is processor
    logic                  flush_req_r;

    pha_sync #(.W(1)) u_rst_sync (
        .clk (clk_pci),
        .d   (rst_b),
        .q   (rst_pci_b)
    );

    pha_sync #(.W(6)) u_pin_sync (
        .clk (clk_pci),
        .d   ({trdy_b_i, irdy_b_i, frame_b_i, req_b}),
        .q   (pin_s)
    );

    // settings are quasi-static, so a plain bus sync is enough
    pha_sync #(.W(10)) u_x_sync (
        .clk (clk_pci),
        .d   ({cfg_in, cpu_req, halt_tgl_r, flush_ack_r}),
        .q   (x_s)
    );

    pha_sync #(.W(2)) u_sys_sync (
        .clk (clk_sys),
        .d   ({flush_req_r, gnt_r[3]}),
        .q   (sys_s)
    );

    assign cfg_s = pha_pkg::pha_cfg_t'(x_s[9:3]);

    // ---------------- bus domain state ----------------
    pha_pkg::pha_arb_st_t st_r;
    pha_pkg::pha_sc_st_t  sc_st_r;
    logic [1:0]  owner_r;     // current or last granted agent
    logic [1:0]  prev_r;      // agent before the owner
    logic [1:0]  pend_r;      // agent waiting on the flush
    logic [4:0]  idle_cnt_r;  // idle clocks under the grant
    logic [2:0]  sc_cnt_r;    // data phase clocks
    logic        frame_d_r;   // frame one clock ago
    logic        halt_d_r;    // halt toggle one clock ago
    logic        halt_pend_r; // halt message still owed
    logic        sc_done;
    logic [3:0]  req_all;
    logic        bus_busy;
    logic        frm_start;
    logic        flush_ack_s;
    logic [2:0]  win;         // winner for a fresh grant
    logic [2:0]  rest;        // winner other than the owner
    logic [2:0]  pre;         // winner judged against the agent before the owner

    assign flush_ack_s = x_s[0];
    assign req_all   = {x_s[2] | halt_pend_r, ~pin_s[2:0]};
    assign frm_start = frame_d_r & ~pin_s[3];
    assign bus_busy  = ~pin_s[3] | ~pin_s[4] | (sc_st_r != pha_pkg::PHA_SC_IDLE);
    assign win  = pick(req_all, cfg_s, owner_r);
    assign rest = pick(req_all & ~(4'h1 << owner_r), cfg_s, owner_r);
    assign pre  = pick(req_all, cfg_s, prev_r);
    assign gnt_b = ~gnt_r[2:0];

    // edge history of frame and the halt toggle
    always_ff @(posedge clk_pci) begin
        if (!rst_pci_b) begin
            frame_d_r <= 1'b1;
            halt_d_r  <= 1'b0;
        end else begin
            frame_d_r <= pin_s[3];
            halt_d_r  <= x_s[1];
        end
    end

    // halt owed; a new event wins over the clear
    always_ff @(posedge clk_pci) begin
        if (!rst_pci_b) begin
            halt_pend_r <= 1'b0;
        end else begin
            halt_pend_r <= (halt_pend_r & ~sc_done) | (x_s[1] ^ halt_d_r);
        end
    end

    // grant sequencer
    always_ff @(posedge clk_pci) begin
        if (!rst_pci_b) begin
            st_r        <= pha_pkg::PHA_ST_IDLE;
            gnt_r       <= `PHA_GNT_RST;
            owner_r     <= `PHA_OWNER_RST;
            prev_r      <= 2'h0;
            pend_r      <= 2'h0;
            idle_cnt_r  <= 5'h00;
            flush_req_r <= 1'b0;
        end else begin
            unique case (st_r)
                pha_pkg::PHA_ST_IDLE: begin
                    idle_cnt_r <= 5'h00;
                    if (win[2] && win[1:0] == owner_r) begin
                        // same agent again: buffers need no flush
                        gnt_r <= 4'h1 << win[1:0];
                        st_r  <= pha_pkg::PHA_ST_GRANT;
                    end else if (win[2] && !flush_ack_s) begin
                        pend_r      <= win[1:0];
                        flush_req_r <= 1'b1;
                        st_r        <= pha_pkg::PHA_ST_FLUSH;
                    end
                end
                pha_pkg::PHA_ST_FLUSH: begin
                    // old grant stands until the buffers are empty
                    if (flush_ack_s) begin
                        gnt_r       <= 4'h1 << pend_r;
                        prev_r      <= owner_r;
                        owner_r     <= pend_r;
                        flush_req_r <= 1'b0;
                        idle_cnt_r  <= 5'h00;
                        st_r        <= pha_pkg::PHA_ST_GRANT;
                    end
                end
                pha_pkg::PHA_ST_GRANT: begin
                    if (frm_start) begin
                        idle_cnt_r <= 5'h00;
                        // owner started: pick who goes next
                        if (rest[2] && !flush_ack_s) begin
                            pend_r      <= rest[1:0];
                            flush_req_r <= 1'b1;
                            st_r        <= pha_pkg::PHA_ST_FLUSH;
                        end
                    end else if (!bus_busy) begin
                        // a running transaction is never touched
                        if (!req_all[owner_r] ||
                            (pre[2] && pre[1:0] != owner_r)) begin
                            gnt_r <= `PHA_GNT_RST;
                            st_r  <= pha_pkg::PHA_ST_IDLE;
                        end else if (owner_r != `PHA_CPU_ID &&
                                     idle_cnt_r == `PHA_GNT_TIMEOUT_CLKS) begin
                            gnt_r <= `PHA_GNT_RST;
                            st_r  <= pha_pkg::PHA_ST_IDLE;
                        end else begin
                            idle_cnt_r <= idle_cnt_r + 5'h01;
                        end
                    end
                end
                default: begin
                    st_r <= pha_pkg::PHA_ST_IDLE;
                end
            endcase
        end
    end

    // halt special cycle, run while the processor holds the bus
    always_ff @(posedge clk_pci) begin
        if (!rst_pci_b) begin
            sc_st_r  <= pha_pkg::PHA_SC_IDLE;
            sc_cnt_r <= 3'h0;
            pci_drv  <= '{frame_b: 1'b1, frame_oe: 1'b0, irdy_b: 1'b1,
                          irdy_oe: 1'b0, cbe_b: 4'hF, ad: 32'h0000_0000,
                          dat_oe: 1'b0};
        end else begin
            unique case (sc_st_r)
                pha_pkg::PHA_SC_IDLE: begin
                    pci_drv.frame_oe <= 1'b0;
                    pci_drv.irdy_oe  <= 1'b0;
                    pci_drv.dat_oe   <= 1'b0;
                    if (halt_pend_r && gnt_r[3] && pin_s[3] && pin_s[4] &&
                        st_r == pha_pkg::PHA_ST_GRANT) begin
                        pci_drv.frame_b  <= 1'b0;
                        pci_drv.frame_oe <= 1'b1;
                        pci_drv.irdy_b   <= 1'b1;
                        pci_drv.irdy_oe  <= 1'b1;
                        pci_drv.cbe_b    <= `PHA_CBE_SPECIAL;
                        pci_drv.ad       <= 32'h0000_0000;     // any value
                        pci_drv.dat_oe   <= 1'b1;
                        sc_st_r          <= pha_pkg::PHA_SC_ADDR;
                    end
                end
                pha_pkg::PHA_SC_ADDR: begin
                    // single data phase follows with no dead clock
                    pci_drv.frame_b <= 1'b1;
                    pci_drv.irdy_b  <= 1'b0;
                    pci_drv.cbe_b   <= `PHA_CBE_HALT_DATA;
                    pci_drv.ad      <= {16'h0000, `PHA_MSG_HALT};
                    sc_cnt_r        <= 3'h0;
                    sc_st_r         <= pha_pkg::PHA_SC_DATA;
                end
                pha_pkg::PHA_SC_DATA: begin
                    // broadcast gets no target, so bound the wait
                    if (!pin_s[5] || sc_cnt_r == `PHA_SC_ABORT_CLKS) begin
                        pci_drv.irdy_b <= 1'b1;
                        pci_drv.dat_oe <= 1'b0;
                        sc_st_r        <= pha_pkg::PHA_SC_TURN;
                    end else begin
                        sc_cnt_r <= sc_cnt_r + 3'h1;
                    end
                end
                pha_pkg::PHA_SC_TURN: begin
                    // control lines driven high one clock, then let go
                    pci_drv.frame_oe <= 1'b0;
                    pci_drv.irdy_oe  <= 1'b0;
                    sc_st_r          <= pha_pkg::PHA_SC_IDLE;
                end
            endcase
        end
    end

    assign sc_done = (sc_st_r == pha_pkg::PHA_SC_TURN);

    // ---------------- checks ----------------
    default clocking cb_pci @(posedge clk_pci); endclocking
    // raw reset too: the bus-side reset is unknown for its first edges
    default disable iff (!rst_b || !rst_pci_b);

    a_grant_same_agent: assert property (
        st_r == pha_pkg::PHA_ST_IDLE && win[2] && win[1:0] == owner_r
        |=> gnt_r == (4'h1 << $past(win[1:0])))
        else $error("fresh grant not given to winner");
    a_grant_timeout: assert property (
        st_r == pha_pkg::PHA_ST_GRANT && !bus_busy && !frm_start &&
        owner_r != `PHA_CPU_ID && idle_cnt_r == `PHA_GNT_TIMEOUT_CLKS
        |=> gnt_r == `PHA_GNT_RST && st_r == pha_pkg::PHA_ST_IDLE)
        else $error("idle grant kept past timeout");
    a_preempt_drop: assert property (
        st_r == pha_pkg::PHA_ST_GRANT && !bus_busy && !frm_start &&
        pre[2] && pre[1:0] != owner_r
        |=> gnt_r == `PHA_GNT_RST)
        else $error("grant kept despite higher request");
    a_busy_keeps_gnt: assert property (
        st_r == pha_pkg::PHA_ST_GRANT && bus_busy && !frm_start
        |=> $stable(gnt_r))
        else $error("grant moved during transaction");
    a_rearb_swap: assert property (
        st_r == pha_pkg::PHA_ST_FLUSH && flush_ack_s
        |=> gnt_r == (4'h1 << $past(pend_r)) && owner_r == $past(pend_r))
        else $error("grant not handed to next winner");
    a_flush_holds: assert property (
        st_r == pha_pkg::PHA_ST_FLUSH && !flush_ack_s
        |=> $stable(gnt_r))
        else $error("grant changed before flush done");
    a_sc_no_turn: assert property (
        sc_st_r == pha_pkg::PHA_SC_ADDR |=> sc_st_r == pha_pkg::PHA_SC_DATA
        ##0 !pci_drv.irdy_b)
        else $error("gap between address and data phase");
    a_sc_trdy_wait: assert property (
        sc_st_r == pha_pkg::PHA_SC_DATA && pin_s[5] &&
        sc_cnt_r < `PHA_SC_ABORT_CLKS |=> sc_st_r == pha_pkg::PHA_SC_DATA)
        else $error("data phase ended without target ready");
    a_sc_addr_phase: assert property (
        sc_st_r == pha_pkg::PHA_SC_ADDR |-> pci_drv.cbe_b ==
        `PHA_CBE_SPECIAL && !pci_drv.frame_b && pci_drv.dat_oe)
        else $error("bad halt address phase");
    a_sc_data_phase: assert property (
        sc_st_r == pha_pkg::PHA_SC_DATA |-> pci_drv.cbe_b ==
        `PHA_CBE_HALT_DATA && pci_drv.ad[15:0] == `PHA_MSG_HALT)
        else $error("bad halt data phase");
    a_fixed_order: assert property (
        cfg_s == 7'h00 && req_all[0] |-> win == 3'h4)
        else $error("fixed order not honoured");
    a_alt_cpu_turn: assert property (
        cfg_s.alternate_processor_priority && req_all[3] &&
        owner_r != `PHA_CPU_ID |-> win == {1'b1, `PHA_CPU_ID})
        else $error("processor skipped its turn");
    a_gnt_onehot: assert property (
        $onehot0(gnt_r) && (gnt_b == ~gnt_r[2:0]))
        else $error("more than one grant");

    c_timeout: cover property (
        st_r == pha_pkg::PHA_ST_GRANT ##1 st_r == pha_pkg::PHA_ST_IDLE);
    c_swap: cover property (
        frm_start && rest[2] ##[1:40] st_r == pha_pkg::PHA_ST_GRANT);
    c_halt: cover property (
        sc_st_r == pha_pkg::PHA_SC_ADDR ##[2:8] sc_done);

endmodule

`default_nettype wire

// ==== test/pha_agents.sv ====
`timescale 1ns/100ps
`default_nettype none

// external masters and one target on the far side of the bus
module pha_agents (
    // bus clock and reset
    input  wire logic       clk_pci,
    input  wire logic       rst_b,
    // which masters want the bus, and whether they may start
    input  wire logic [2:0] want,
    input  wire logic       go,
    // resolved bus lines and grants
    input  wire logic [2:0] gnt_b,
    input  wire logic       frame_w,
    input  wire logic       irdy_w,
    // lines the agents drive
    output logic      [2:0] req_b,
    output logic            frame_b,
    output logic            frame_oe,
    output logic            irdy_b,
    output logic            trdy_b
);
    logic [1:0] ph_r;   // phase of the active master's write

    // requests follow the wishes of the bench
    always_ff @(posedge clk_pci) begin
        req_b <= ~want;
    end

    // target: one wait clock, then ready for one clock
    always_ff @(posedge clk_pci) begin
        trdy_b <= !(!irdy_w && trdy_b);
    end

    // master: single-phase write started as soon as granted on idle bus
    always_ff @(posedge clk_pci) begin
        if (!rst_b) begin
            ph_r <= 2'h0;
            frame_oe <= 1'b0;
            frame_b <= 1'b1;
            irdy_b <= 1'b1;
        end else if (ph_r == 2'h0) begin
            // start well inside the sixteen clock limit
            if (go && frame_w && irdy_w && |(~gnt_b & want)) begin
                ph_r <= 2'h1;
                frame_oe <= 1'b1;
                frame_b <= 1'b0;
            end
        end else if (ph_r == 2'h1) begin
            // data phase follows the address phase directly
            ph_r <= 2'h2;
            frame_b <= 1'b1;
            irdy_b <= 1'b0;
        end else if (ph_r == 2'h2) begin
            // hold until target ready is seen
            if (!trdy_b) begin
                ph_r <= 2'h3;
                irdy_b <= 1'b1;
            end
        end else begin
            // release frame; the pull-up takes it high, irdy is already driven high
            ph_r <= 2'h0;
            frame_oe <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ==== test/pci_host_arbiter_halt_broadcast_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pha_consts.svh"

module pci_host_arbiter_halt_broadcast_tb;
    logic clk_sys = 0, clk_pci = 0, rst_b = 0;
    logic cpu_req = 0, halt_exec = 0, buf_empty = 1, go = 0;
    logic buf_flush, cpu_grant, a_frame_b, a_frame_oe, a_irdy_b, trdy_b;
    logic [2:0] want = 3'h0, req_b, gnt_b;
    logic frame_w, irdy_w, flushed = 0;
    pha_pkg::pha_cfg_t cfg = '0;
    pha_pkg::pha_drv_t drv;
    int failures = 0, checked = 0, cyc = 0, n;

    always #12.5 clk_sys = ~clk_sys;
    always #24 clk_pci = ~clk_pci;
    // frame is pulled up and driven by whoever enables it; irdy comes from the block when enabled, else from the agents
    assign frame_w = drv.frame_oe ? drv.frame_b : (a_frame_oe ? a_frame_b : 1'b1);
    assign irdy_w = drv.irdy_oe ? drv.irdy_b : a_irdy_b;
    // buffers drain one clock after a flush request
    always @(posedge clk_sys) begin
        buf_empty <= buf_flush;
        if (buf_flush) flushed <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            print_verdict();
        end
    end

    pha_arbiter DUT (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_in(cfg),
        .cpu_req(cpu_req), .halt_exec(halt_exec), .buf_empty(buf_empty),
        .buf_flush(buf_flush), .cpu_grant(cpu_grant), .clk_pci(clk_pci),
        .req_b(req_b), .frame_b_i(frame_w), .irdy_b_i(irdy_w),
        .trdy_b_i(trdy_b), .gnt_b(gnt_b), .pci_drv(drv));
    pha_agents AGT (.clk_pci(clk_pci), .rst_b(rst_b), .want(want), .go(go),
        .gnt_b(gnt_b), .frame_w(frame_w), .irdy_w(irdy_w), .req_b(req_b),
        .frame_b(a_frame_b), .frame_oe(a_frame_oe), .irdy_b(a_irdy_b),
        .trdy_b(trdy_b));

    // one comparison, reported at once on mismatch
    task automatic chk(input logic ok, input string m);
        checked++;
        if (!ok) begin
            failures++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask

    // wait, bounded, for the grant lines to show a value
    task automatic wait_gnt(input logic [2:0] g, input string m);
        n = 0;
        while (gnt_b !== g && n < 400) begin
            @(posedge clk_pci);
            #1 n++;
        end
        chk(gnt_b === g, m);
    endtask

    // unused grant withdrawn after sixteen idle clocks
    task automatic t_timeout();
        @(posedge clk_sys) want <= 3'h1;
        wait_gnt(3'h6, "no grant to master 0");
        wait_gnt(3'h7, "grant not withdrawn");
        chk(n >= 16 && n <= 18, "timeout length wrong");
        @(posedge clk_sys) want <= 3'h0;
        repeat (8) @(posedge clk_pci);
    endtask

    // frame start re-arbitrates with flush; requester served again
    task automatic t_swap();
        go <= 1'b1;
        @(posedge clk_sys) want <= 3'h2;
        wait_gnt(3'h5, "no grant to master 1");
        flushed <= 1'b0;
        @(posedge clk_sys) want <= 3'h3;
        wait_gnt(3'h6, "grant not moved on frame");
        chk(flushed === 1'b1, "grant moved without flush");
        // master 1 kept asking; master 0 now drops out
        @(posedge clk_sys) want <= 3'h2;
        wait_gnt(3'h5, "master 1 not granted again");
        @(posedge clk_sys) want <= 3'h0;
        go <= 1'b0;
        repeat (8) @(posedge clk_pci);
    endtask

    // processor request then halt broadcast
    task automatic t_halt();
        @(posedge clk_sys) cpu_req <= 1'b1;
        n = 0;
        while (cpu_grant !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(cpu_grant === 1'b1, "processor not granted");
        @(posedge clk_sys) cpu_req <= 1'b0;
        halt_exec <= 1'b1;
        @(posedge clk_sys) halt_exec <= 1'b0;
        n = 0;
        while (!(drv.frame_oe === 1'b1 && drv.frame_b === 1'b0) && n < 400) begin
            @(posedge clk_pci);
            #1 n++;
        end
        chk(drv.cbe_b === `PHA_CBE_SPECIAL, "halt command wrong");
        @(posedge clk_pci);
        #1 chk(drv.cbe_b === `PHA_CBE_HALT_DATA, "halt enables wrong");
        chk(drv.ad[15:0] === `PHA_MSG_HALT, "halt code wrong");
        chk(drv.irdy_b === 1'b0 && drv.frame_b === 1'b1, "data phase late");
        n = 0;
        while (drv.irdy_b === 1'b0 && n < 20) begin
            @(posedge clk_pci);
            #1 n++;
        end
        chk(drv.irdy_b === 1'b1 && n >= 2 && n <= 6, "data phase end wrong");
        repeat (12) @(posedge clk_pci);
    endtask

    // verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        #1 chk(gnt_b === `PHA_GNT_RST ^ 3'h7, "grants not idle in reset");
        rst_b <= 1'b1;
        repeat (6) @(posedge clk_pci);
        t_timeout();
        t_swap();
        t_halt();
        print_verdict();
    end
endmodule

`default_nettype wire
